// ===== logic/sdt_pkg.sv
// shared constants for the serial byte engine: register map, field layout, timing
package sdt_pkg;

  // bus and counter widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 12;

  // register offsets
  localparam logic [7:0] OFS_CONTROL  = 8'hC0;
  localparam logic [7:0] OFS_CONFIG   = 8'hC1;
  localparam logic [7:0] OFS_DATA     = 8'hC2;
  localparam logic [7:0] OFS_OWN_ADDR = 8'hC3;

  // control register bit positions
  localparam int CTL_MASTER  = 7;
  localparam int CTL_TXMODE  = 6;
  localparam int CTL_STA     = 5;
  localparam int CTL_STO     = 4;
  localparam int CTL_ACK_REQUEST_FLAG   = 3;
  localparam int CTL_ARBLOST = 2;
  localparam int CTL_ACK     = 1;
  localparam int CTL_SI      = 0;

  // config register bit positions
  localparam int CFG_INHIBIT = 0;

  // reset values
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic [7:0] RST_CONFIG   = 8'h00;
  localparam logic [7:0] RST_DATA     = 8'h00;
  localparam logic [6:0] RST_OWN_ADDR = 7'h00;

  // bit positions inside a byte frame
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;

  // timing: serial clock half period, least time, so rounded up
  localparam int CLK_NS       = 4;
  localparam int SCL_HALF_NS  = 1250;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;

  // master clock engine states
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_START = 3'b001,
    M_LOW   = 3'b010,
    M_HIGH  = 3'b011,
    M_STOP1 = 3'b100,
    M_STOP2 = 3'b101
  } sdt_mstate_t;

endpackage

// ===== logic/sdt_core.sv
// serial two-wire byte engine: data register, four transfer modes, pin drive
// Functional notes
// [RQ1] data byte free and stable while flag set
// [RQ2] software avoids data byte while flag clear
// [RQ3] outgoing bytes leave most significant bit first
// [RQ4] first received bit lands in MSB
// [RQ5] bus data shifted in while shifting out
// [RQ6] lost arbitration drops to slave receiver
// [RQ7] master from START until STOP or loss
// [RQ8] byte event before ack receiving, after transmitting
// [RQ9] master write: START, address, data bytes
// [RQ10] master ends only by stop request
// [RQ11] no data write: master transmitter becomes receiver
// [RQ12] master read: address then clocked receive
// [RQ13] received byte sets ack request and event
// [RQ14] ack level bit chooses ACK or NACK
// [RQ15] software NACKs last byte then stops
// [RQ16] data write: master receiver becomes transmitter
// [RQ17] uninhibited address match enters slave receiver
// [RQ18] NACKed address blocks slave until START
// [RQ19] slave receiver ends on STOP, write→transmitter
// [RQ20] slave transmitter reloads per ACK, ends STOP
// [RQ21] software avoids data write after master NACK
// [RQ22] no data write: slave transmitter becomes receiver
// [RQ23] flag set stalls bus, SCL held low
// [RQ24] flag set by hardware, cleared by software
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
module sdt_core
  import sdt_pkg::*;
#(
  parameter int HALF_CYC = SCL_HALF_CYC
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // serial clock pin
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe,
  // serial data pin
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe
);

  // the half period counter must fit and leave room for setup
  if (HALF_CYC < 4 || HALF_CYC >= (1 << CNT_W)) begin : g_bad_half
    $error("HALF_CYC out of range");
  end

  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus event detection

  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;

  // three flops per pin; only the second stage and its delayed copy are looked at
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
    end
  end

  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_det = sda_d & ~sda_s & scl_s & scl_d;
  wire stop_det  = ~sda_d & sda_s & scl_s & scl_d;

  //////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]       shreg;
  logic             master, txmode, sta, stop_request_bit, ackreq, arblost, ack, si;
  logic             inhibit;
  logic [6:0]       own_addr;
  logic [3:0]       bitcnt;
  logic             busy, addr_phase, addressed, addr_ack, nack_block;
  logic             data_written, data_low, m_force, hold_scl;
  sdt_mstate_t      mstate;
  logic [CNT_W-1:0] cnt;

  //////////////////////////////////////////////////////////////////////////////
  // register decode

  wire wr_ctl = reg_wr & (reg_addr == OFS_CONTROL);
  wire wr_cfg = reg_wr & (reg_addr == OFS_CONFIG);
  wire wr_dat = reg_wr & (reg_addr == OFS_DATA);
  wire wr_own = reg_wr & (reg_addr == OFS_OWN_ADDR);

  wire [7:0] ctl_view = {master, txmode, sta, stop_request_bit, ackreq, arblost, ack, si};
  wire [7:0] rd_mux   = (reg_addr == OFS_CONTROL)  ? ctl_view :
                        (reg_addr == OFS_CONFIG)   ? {7'h00, inhibit} :
                        (reg_addr == OFS_DATA)     ? shreg :
                        (reg_addr == OFS_OWN_ADDR) ? {own_addr, 1'b0} : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // byte frame events; no rising clock edge is acted on while stalled

  wire part     = master | addressed;
  wire rise_ok  = scl_rise & ~si;
  wire arb_evt  = rise_ok & master & txmode & (bitcnt < BIT_ACK) & ~data_low & ~sda_s;
  wire addr_done = rise_ok & addr_phase & ~master & (bitcnt == BIT_LAST);
  wire addr_hit = addr_done & (shreg[6:0] == own_addr) & ~inhibit & ~nack_block;
  wire rx_byte  = rise_ok & part & ~txmode & (bitcnt == BIT_LAST);
  wire ack_rise = rise_ok & (bitcnt == BIT_ACK);
  wire tx_ack   = ack_rise & part & txmode & ~ackreq;
  wire sl_stop  = stop_det & addressed;
  wire cnt_done = (cnt == HALF_LAST);
  wire start_done = (mstate == M_START) & cnt_done;
  wire stop_done  = (mstate == M_STOP2) & scl_s & cnt_done;

  wire hw_si_set = start_done | arb_evt | tx_ack | rx_byte | addr_hit | sl_stop; // [RQ8] [RQ13]
  wire sw_si_clr = wr_ctl & ~reg_wdata[CTL_SI];
  wire si_clr    = sw_si_clr & si & ~hw_si_set;

  //////////////////////////////////////////////////////////////////////////////
  // next values of the control flags

  logic next_si, next_master, next_txmode, next_ack, next_sto;
  logic [7:0] next_shreg;

  always_comb begin
    // set by hardware beats a software clear in the same cycle
    next_si = hw_si_set | (si & ~sw_si_clr);                    // [RQ24]
    next_master = master;
    if (start_done) next_master = 1'b1;                         // [RQ7]
    else if (arb_evt | stop_done) next_master = 1'b0;           // [RQ7] [RQ6]
    next_txmode = txmode;
    if (start_done) next_txmode = 1'b1;                         // [RQ9]
    else if (arb_evt | stop_done | sl_stop) next_txmode = 1'b0; // [RQ6] [RQ19] [RQ20]
    else if (start_det & ~master) next_txmode = 1'b0;
    // direction for the next frame follows whether software loaded a byte
    else if (si_clr & part) next_txmode = data_written;         // [RQ11] [RQ16] [RQ19] [RQ22]
    next_ack = ack;
    if (tx_ack) next_ack = ~sda_s;
    else if (wr_ctl) next_ack = reg_wdata[CTL_ACK];             // [RQ14]
    next_sto = stop_request_bit;
    if (stop_done) next_sto = 1'b0;                             // [RQ10]
    else if (sl_stop) next_sto = 1'b1;
    else if (wr_ctl) next_sto = reg_wdata[CTL_STO];
    // shift in from the bus, msb first, also while sending
    next_shreg = shreg;
    if (rise_ok & busy & (bitcnt < BIT_ACK)) next_shreg = {shreg[6:0], sda_s}; // [RQ4] [RQ5]
    else if (wr_dat) next_shreg = reg_wdata;                    // [RQ1]
  end

  //////////////////////////////////////////////////////////////////////////////
  // data line drive, set low only while the clock line is low

  logic next_data_low;

  always_comb begin
    next_data_low = data_low;
    if (arb_evt | stop_done | stop_det) begin
      next_data_low = 1'b0;                                     // [RQ6]
    end else if (scl_fall | si_clr) begin
      if (next_si) next_data_low = 1'b0;
      else if (bitcnt < BIT_ACK) next_data_low = part & next_txmode & ~next_shreg[7]; // [RQ3]
      else next_data_low = part & ackreq & next_ack;            // [RQ14]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // master clock engine

  sdt_mstate_t next_mstate;
  logic [CNT_W-1:0] next_cnt;

  always_comb begin
    next_mstate = mstate;
    next_cnt = cnt + CNT_W'(1);
    unique case (mstate)
      M_IDLE: begin
        next_cnt = '0;
        if (sta & ~busy & ~master & ~si) next_mstate = M_START;
      end
      M_START: begin
        if (cnt_done) begin
          next_mstate = M_LOW;
          next_cnt = '0;
        end
      end
      M_LOW: begin
        // a stall restarts the low time so data gets a full setup
        if (~master) next_mstate = M_IDLE;
        else if (si) next_cnt = '0;                             // [RQ23]
        else if (cnt_done) begin
          next_mstate = ((bitcnt == 4'h0) & stop_request_bit) ? M_STOP1 : M_HIGH; // [RQ10]
          next_cnt = '0;
        end
      end
      M_HIGH: begin
        // counting waits for the line to rise, so stretched clocks are obeyed
        if (~master) next_mstate = M_IDLE;
        else if (~scl_s) next_cnt = '0;
        else if (cnt_done) begin
          next_mstate = M_LOW;
          next_cnt = '0;
        end
      end
      M_STOP1: begin
        if (cnt_done) begin
          next_mstate = M_STOP2;
          next_cnt = '0;
        end
      end
      M_STOP2: begin
        if (~scl_s) next_cnt = '0;
        else if (cnt_done) next_mstate = M_IDLE;
      end
      default: begin
        next_mstate = M_IDLE;
        next_cnt = '0;
      end
    endcase
  end

  wire next_m_low  = (next_mstate == M_LOW) | (next_mstate == M_STOP1);
  wire next_force  = (next_mstate == M_START) | (next_mstate == M_STOP1) | (next_mstate == M_STOP2) |
                     (m_force & ~scl_fall & (next_mstate == M_LOW));
  wire next_hold   = (next_si | si) & (hold_scl | scl_fall); // one cycle past the clear: new bit gets setup

  //////////////////////////////////////////////////////////////////////////////
  // register updates

  // software visible flags and data
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      {master, txmode, sta, stop_request_bit, ackreq, arblost, ack, si} <= RST_CONTROL;
      shreg <= RST_DATA;
    end else begin
      si      <= next_si;                                       // [RQ23]
      master  <= next_master;
      txmode  <= next_txmode;
      ack     <= next_ack;
      stop_request_bit     <= next_sto;
      shreg   <= next_shreg;
      sta     <= start_done ? 1'b0 : (wr_ctl ? reg_wdata[CTL_STA] : sta);
      ackreq  <= (rx_byte | addr_hit) | (ackreq & ~ack_rise); // [RQ13] [RQ17]
      arblost <= arb_evt | (arblost & ~si_clr);
    end
  end

  // configuration
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      inhibit  <= RST_CONFIG[CFG_INHIBIT];
      own_addr <= RST_OWN_ADDR;
    end else begin
      if (wr_cfg) inhibit <= reg_wdata[CFG_INHIBIT];
      if (wr_own) own_addr <= reg_wdata[7:1];
    end
  end

  // frame tracking
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      {busy, addr_phase, addressed, addr_ack, nack_block, data_written} <= 6'h00;
      bitcnt <= 4'h0;
    end else begin
      bitcnt     <= start_det ? 4'h0 : (rise_ok ? ((bitcnt == BIT_ACK) ? 4'h0 : bitcnt + 4'h1) : bitcnt);
      busy       <= start_det | (busy & ~stop_det);
      addr_phase <= start_det | (addr_phase & ~addr_done & ~stop_det);
      addressed  <= ~start_det & ~stop_det & (addr_hit | (addressed & ~(ack_rise & addr_ack & ~ack)));
      addr_ack   <= addr_hit | (addr_ack & ~ack_rise);
      nack_block <= ~start_det & (nack_block | (ack_rise & addr_ack & ~ack)); // [RQ18]
      data_written <= wr_dat | (data_written & ~si_clr);
    end
  end

  // master engine and pin drive
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mstate   <= M_IDLE;
      cnt      <= '0;
      {data_low, m_force, hold_scl} <= 3'h0;
      {scl_oe, sda_oe, scl_o, sda_o} <= 4'h0;
    end else begin
      mstate   <= next_mstate;
      cnt      <= next_cnt;
      data_low <= next_data_low;
      m_force  <= next_force;
      hold_scl <= next_hold;
      scl_oe   <= next_hold | next_m_low;                       // [RQ12] [RQ23]
      sda_oe   <= next_force | next_data_low;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rstn) reg_rdata <= 8'h00;
    else reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_data_held_si: assert property (si && $past(si) && !$past(wr_dat) |-> $stable(shreg)) // [RQ1]
    else $error("data byte moved while event flag set");

  a_msb_out_first: assert property (scl_fall && !next_si && part && next_txmode && bitcnt < BIT_ACK
      && !(arb_evt | stop_done | stop_det) |=> data_low == !$past(shreg[7])) // [RQ3]
    else $error("outgoing bit is not the msb");

  a_shift_into_msb: assert property (rise_ok && busy && bitcnt == 4'h0 |-> ##1 shreg[0] == $past(sda_s)) // [RQ4]
    else $error("first received bit not entering the shift chain");

  a_arb_drop: assert property (arb_evt |=> !master && !txmode && arblost && si && !data_low) // [RQ6]
    else $error("lost arbitration did not fall to slave receiver");

  a_rx_event_early: assert property (rx_byte |=> si && ackreq && bitcnt == BIT_ACK) // [RQ8] [RQ13]
    else $error("receive event not raised before ack cycle");

  a_tx_event_late: assert property (tx_ack |=> si && bitcnt == 4'h0 && ack == !$past(sda_s)) // [RQ8]
    else $error("transmit event not raised after ack cycle");

  a_ack_level: assert property (si_clr && ackreq && bitcnt == BIT_ACK && part |=> data_low == ack) // [RQ14]
    else $error("ack drive does not follow ack level bit");

  a_mode_pick: assert property (si_clr && part && !arb_evt && !stop_done && !sl_stop && !start_det
      |=> txmode == $past(data_written)) // [RQ11] [RQ16] [RQ22]
    else $error("direction not chosen by data write");

  a_slave_enter: assert property (addr_hit |=> si && ackreq && addressed ##0 !txmode) // [RQ17]
    else $error("address match did not enter slave receiver");

  a_nack_blocks: assert property (ack_rise && addr_ack && !ack |=> nack_block && !addressed) // [RQ18]
    else $error("nacked address did not block slave events");

  a_stall_holds: assert property (si && scl_oe |=> scl_oe || !si) // [RQ23]
    else $error("clock line released during stall");

  a_flag_sticky: assert property (si && !sw_si_clr |=> si) // [RQ24]
    else $error("event flag cleared without software");

  a_stop_ends: assert property (stop_done |=> !master && !stop_request_bit && !sda_oe ##1 mstate == M_IDLE) // [RQ7] [RQ10]
    else $error("stop did not end master mode");

endmodule

// ===== test/sdt_bm.sv
// bus partner: slave to the block's master, master to its slave
`timescale 1ns/1ns
module sdt_bm (
  // resolved bus lines
  input  wire logic scl,
  input  wire logic sda,
  // partner pull-low enables
  output logic      scl_oe,
  output logic      sda_oe
);
  // released lines float up through the pull-ups
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // slave role: frames clocked by the block
  task automatic wait_start;
    @(negedge sda iff scl);
  endtask
  task automatic wait_stop;
    @(posedge sda iff scl);
  endtask
  // late sda moves keep clear of a false start or stop
  task automatic get_byte(output logic [7:0] b, input logic ack);
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
    @(negedge scl);
    #8 sda_oe = ack;
    @(negedge scl);
    #8 sda_oe = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      sda_oe = ~b[i];
      @(posedge scl);
      @(negedge scl);
      #8;
    end
    sda_oe = 1'b0;
    @(posedge scl);
    #4 nack = sda;
    @(negedge scl);
  endtask
  ////////////////////////////////////////////////////////////
  // master role: 48 ns bit time, stretched while the block stalls
  task automatic put_bit(input logic v, output logic r);
    sda_oe = ~v;
    #16 scl_oe = 1'b0;
    wait (scl);
    #4 r = sda;
    #20 scl_oe = 1'b1;
    #8;
  endtask
  task automatic start_frame;
    sda_oe = 1'b1;
    #24 scl_oe = 1'b1;
    #8;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(b[i], r);
    put_bit(1'b1, r);
    ack = ~r;
  endtask
  // eight bits read from the block, then our own ack level
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic r;
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      put_bit(1'b1, r);
      b = {b[6:0], r};
    end
    put_bit(~ack, r);
  endtask
  // holds data low across the block's first bit, then lets it rise as a stop
  task automatic clash_stop;
    @(negedge sda iff scl);
    @(negedge scl);
    #8 sda_oe = 1'b1;
    #800 sda_oe = 1'b0;
  endtask
  task automatic stop_frame;
    sda_oe = 1'b1;
    #24 scl_oe = 1'b0;
    wait (scl);
    #24 sda_oe = 1'b0;
    #24;
  endtask
endmodule

// ===== test/testbench.sv
// self-checking bench: register port tasks against a bus partner
`timescale 1ns/1ns
module testbench;
  import sdt_pkg::*;
  // short bus half period keeps the run brief
  localparam int HC = 8;
  logic       clk_sys, rstn, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       scl_o, scl_oe, sda_o, sda_oe, m_scl_oe, m_sda_oe;
  wire        scl, sda;
  int         err_total, total_checks, cyc;
  // open-drain lines with pull-ups
  assign scl = ~(scl_oe | m_scl_oe);
  assign sda = ~(sda_oe | m_sda_oe);
  sdt_core #(.HALF_CYC(HC)) sdt_core_inst (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  sdt_bm sdt_bm_inst (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  ////////////////////////////////////////////////////////////
  // 4 ns clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      err_total++;
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////
  // register port tasks; read data stands only in the next cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    logic [7:0] v;
    rd(a, v);
    chk(nm, e, v & m);
  endtask
  // polls control only, never the data byte while shifting
  task automatic wait_si;
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 3000 && v[0] !== 1'b1; i++) rd(OFS_CONTROL, v);
    if (v[0] !== 1'b1) chk("event flag", 8'h01, v);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] b;
    logic       a;
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    rchk(OFS_CONTROL, 8'hFF, RST_CONTROL, "control reset");
    rchk(OFS_DATA, 8'hFF, RST_DATA, "data reset");
    rchk(8'hC7, 8'hFF, 8'h00, "unmapped read");
    // master write of address and one data byte
    fork
      begin
        sdt_bm_inst.wait_start;
        sdt_bm_inst.get_byte(b, 1'b1);
        chk("write address", 8'hA4, b);
        sdt_bm_inst.get_byte(b, 1'b1);
        chk("write data", 8'h5A, b);
        sdt_bm_inst.wait_stop;
      end
      begin
        wr(OFS_CONTROL, 8'h20);
        wait_si;
        rchk(OFS_CONTROL, 8'hFF, 8'hC1, "start status");
        wr(OFS_DATA, 8'hA4);
        rchk(OFS_DATA, 8'hFF, 8'hA4, "data readback");
        wr(OFS_CONTROL, 8'h00);
        wait_si;
        rchk(OFS_CONTROL, 8'hFF, 8'hC3, "acked byte status");
        repeat (40) @(posedge clk_sys);
        chk("clock held low", 8'h00, {7'h00, scl});
        wr(OFS_CONTROL, 8'h01);
        rchk(OFS_CONTROL, 8'h01, 8'h01, "flag kept");
        wr(OFS_DATA, 8'h5A);
        wr(OFS_CONTROL, 8'h00);
        wait_si;
        rchk(OFS_DATA, 8'hFF, 8'h5A, "bus byte kept");
        wr(OFS_CONTROL, 8'h10);
      end
    join
    repeat (20) @(posedge clk_sys);
    rchk(OFS_CONTROL, 8'hFD, 8'h00, "after stop");
    // master read of two bytes, ack then nack
    fork
      begin
        sdt_bm_inst.wait_start;
        sdt_bm_inst.get_byte(b, 1'b1);
        chk("read address", 8'hA5, b);
        sdt_bm_inst.put_byte(8'h3C, a);
        chk("first answer", 8'h00, {7'h00, a});
        sdt_bm_inst.put_byte(8'hC3, a);
        chk("last answer", 8'h01, {7'h00, a});
        sdt_bm_inst.wait_stop;
      end
      begin
        wr(OFS_CONTROL, 8'h20);
        wait_si;
        wr(OFS_DATA, 8'hA5);
        wr(OFS_CONTROL, 8'h00);
        wait_si;
        wr(OFS_CONTROL, 8'h00);
        wait_si;
        rchk(OFS_CONTROL, 8'hFD, 8'h89, "receive status");
        rchk(OFS_DATA, 8'hFF, 8'h3C, "first received");
        wr(OFS_CONTROL, 8'h02);
        wait_si;
        rchk(OFS_DATA, 8'hFF, 8'hC3, "last received");
        wr(OFS_CONTROL, 8'h10);
      end
    join
    repeat (20) @(posedge clk_sys);
    rchk(OFS_CONTROL, 8'hFD, 8'h00, "read ended");
    // slave receiver: address match, one byte, stop
    wr(OFS_OWN_ADDR, 8'h84);
    // refused address: no slave events until the next start
    fork
      begin
        sdt_bm_inst.start_frame;
        sdt_bm_inst.send_byte(8'h84, a);
        chk("refused address", 8'h00, {7'h00, a});
        sdt_bm_inst.send_byte(8'h84, a);
        chk("blocked byte", 8'h00, {7'h00, a});
        sdt_bm_inst.stop_frame;
      end
      begin
        wait_si;
        wr(OFS_CONTROL, 8'h00);
      end
    join
    rchk(OFS_CONTROL, 8'hFF, 8'h00, "no event after refusal");
    fork
      begin
        sdt_bm_inst.start_frame;
        sdt_bm_inst.send_byte(8'h84, a);
        chk("slave address ack", 8'h01, {7'h00, a});
        sdt_bm_inst.send_byte(8'h96, a);
        chk("slave data ack", 8'h01, {7'h00, a});
        sdt_bm_inst.stop_frame;
      end
      begin
        wait_si;
        rchk(OFS_CONTROL, 8'hC9, 8'h09, "slave address event");
        rchk(OFS_DATA, 8'hFF, 8'h84, "slave address byte");
        wr(OFS_CONTROL, 8'h02);
        wait_si;
        rchk(OFS_DATA, 8'hFF, 8'h96, "slave data byte");
        wr(OFS_CONTROL, 8'h02);
        wait_si;
        rchk(OFS_CONTROL, 8'hD1, 8'h11, "stop event");
        wr(OFS_CONTROL, 8'h00);
      end
    join
    // slave transmitter: read address, one byte, master nack, stop
    fork
      begin
        sdt_bm_inst.start_frame;
        sdt_bm_inst.send_byte(8'h85, a);
        chk("read address ack", 8'h01, {7'h00, a});
        sdt_bm_inst.recv_byte(1'b0, b);
        chk("slave sent byte", 8'h3C, b);
        sdt_bm_inst.stop_frame;
      end
      begin
        wait_si;
        wr(OFS_DATA, 8'h3C);
        wr(OFS_CONTROL, 8'h02);
        wait_si;
        rchk(OFS_CONTROL, 8'hFF, 8'h41, "slave transmit event");
        rchk(OFS_DATA, 8'hFF, 8'h3C, "sent byte kept");
        wr(OFS_CONTROL, 8'h00);
        wait_si;
        rchk(OFS_CONTROL, 8'hD1, 8'h11, "transmit stop event");
        wr(OFS_CONTROL, 8'h00);
      end
    join
    // lost arbitration on the first address bit
    fork
      sdt_bm_inst.clash_stop;
      begin
        wr(OFS_CONTROL, 8'h20);
        wait_si;
        wr(OFS_DATA, 8'hC6);
        wr(OFS_CONTROL, 8'h00);
        wait_si;
        rchk(OFS_CONTROL, 8'hFD, 8'h05, "lost arbitration");
        rchk(OFS_DATA, 8'hFF, 8'h8C, "byte after loss");
        wr(OFS_CONTROL, 8'h00);
      end
    join
    wrap_up;
  end
endmodule
